/* File: rtl/gpio_pin_pkg.sv */
// Constants and carrier types for the IO pin function block
package gpio_pin_pkg;
  localparam logic [10:0] CFG_BYTE_ADDR = 11'h439;
  localparam int IN_MODE_LSB = 0;
  localparam int DRV_MODE_LSB = 4;
  localparam int SRC_SEL_LSB = 6;
  localparam logic [7:0] CFG_RESET = 8'h30;
  localparam int BLINK_HIGH_TICKS = 32;
  localparam int BLINK_LOW_TICKS = 992;
  localparam int BLINK_PERIOD_TICKS = BLINK_HIGH_TICKS + BLINK_LOW_TICKS;
  localparam int BLINK_CNT_W = 10;

  typedef enum logic [1:0] {
    IN_PULL_DOWN = 2'h0,
    IN_PULL_LOG = 2'h1,
    IN_START_EDGE = 2'h2,
    IN_LOG_EDGE = 2'h3
  } input_pin_mode_t;

  typedef enum logic [1:0] {
    DRV_PUSH_PULL = 2'h0,
    DRV_PULL_UP = 2'h1,
    DRV_PULL_DOWN = 2'h2,
    DRV_HIGH_Z = 2'h3
  } output_drive_mode_t;

  typedef enum logic [1:0] {
    SRC_COMPARATOR = 2'h0,
    SRC_CMD_BUSY = 2'h1,
    SRC_FIELD = 2'h2,
    SRC_STATUS_OR = 2'h3
  } output_source_select_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAITING,
    ST_ACTIVE
  } log_state_t;

  // Status inputs ORed onto the output pin
  typedef struct packed {
    logic memory_full_flag;
    logic converter_error_flag;
    logic low_battery_flag;
    logic limit_exceeded_flag;
  } status_flags_t;

  // Memory map write port
  typedef struct packed {
    logic we;
    logic [10:0] addr;
    logic [7:0] wdata;
  } cfg_write_t;

  typedef struct packed {
    logic [7:0] cfg;
    logic din_s1;
    logic din_s2;
    logic din_prev;
    log_state_t state;
    logic waiting;
    logic active;
    logic [BLINK_CNT_W-1:0] blink_cnt;
    logic start_pulse;
    logic log_pulse;
    logic in_pull_up;
    logic in_pull_down;
    logic dout_o;
    logic dout_oe;
    logic dout_pull_up;
    logic dout_pull_down;
    logic [7:0] rdata;
  } pin_state_t;
endpackage

/* File: rtl/tag_gpio_pin_function.sv */
// Function logic of the serial input and output pins when used as general purpose IO
`timescale 1ns/1ps

// Summary of operation
// - Chip-enable low and no serial lock: serial pins act as general purpose IO.
// - Input pin mode is bits 1..0 of the configuration byte at 0x439.
// - Input mode 00: plain input with pull-down enabled.
// - Input mode 01: pull-up on only while a logging event runs.
// - Input mode 10: pull-up in waiting; falling edge moves waiting to active.
// - Mode 10 with timed start: delay expiry or falling edge, first wins.
// - Input mode 11: pull-up while active; each falling edge starts one logging event.
// - Chip-enable high: output pin carries serial data, GPIO setup ignored.
// - Drive mode and source apply only with chip-enable low and application mode.
// - Output drive mode is bits 5..4 of the configuration byte.
// - Drive: 00 push-pull, 01 pull-up, 10 pull-down, 11 high-Z default.
// - Pull-down drive mode outputs the inverse of the selected source.
// - Output source select is bits 7..6 of the configuration byte.
// - Source 00: copy of the external interrupt comparator.
// - Source 01: high while a recognised ISO 15693 command is processed.
// - Source 10: high while a reader field is detected.
// - Source 11: OR of memory full, converter error, low battery, limit exceeded.
module tag_gpio_pin_function #(
  // Blink pattern lengths in slow oscillator counts
  parameter int BLINK_HIGH_COUNT = gpio_pin_pkg::BLINK_HIGH_TICKS,
  parameter int BLINK_LOW_COUNT = gpio_pin_pkg::BLINK_LOW_TICKS
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Memory map access to the configuration byte
  input wire gpio_pin_pkg::cfg_write_t cfg_wr_i,
  input wire logic [10:0] cfg_rd_addr_i,
  output logic [7:0] cfg_rdata_o,
  // Serial port and mode
  input wire logic chip_enable_i,
  input wire logic serial_lock_i,
  input wire logic app_mode_i,
  input wire logic serial_dout_i,
  // Logging state control
  input wire logic timed_start_flag_i,
  input wire logic start_delay_done_i,
  input wire logic log_busy_i,
  input wire logic arm_i,
  input wire logic stop_i,
  // Output sources
  input wire logic comparator_i,
  input wire logic cmd_busy_i,
  input wire logic field_i,
  input wire gpio_pin_pkg::status_flags_t status_i,
  input wire logic blink_enable_flag_i,
  input wire logic slow_oscillator_tick_i,
  // Input pin
  input wire logic din_i,
  output logic din_pull_up_o,
  output logic din_pull_down_o,
  output logic start_pulse_o,
  output logic log_event_o,
  output logic waiting_o,
  output logic active_o,
  // Output pin
  output logic dout_o,
  output logic dout_oe_o,
  output logic dout_pull_up_o,
  output logic dout_pull_down_o
);
  import gpio_pin_pkg::*;

  localparam int BLINK_PERIOD = BLINK_HIGH_COUNT + BLINK_LOW_COUNT;

  // The blink counter has a fixed width, so the whole pattern must fit in it
  if (BLINK_HIGH_COUNT < 1 || BLINK_LOW_COUNT < 1 ||
      BLINK_PERIOD > (1 << BLINK_CNT_W)) begin : gen_bad_blink
    $error("blink pattern does not fit the blink counter");
  end

  pin_state_t s_r;
  pin_state_t s_nxt;

  logic gpio_mode;
  logic fall;
  logic src_level;
  logic blink_gate;
  input_pin_mode_t in_mode;
  output_drive_mode_t drv_mode;
  output_source_select_t src_sel;

  always_comb begin
    gpio_mode = !chip_enable_i && !serial_lock_i;
    in_mode = input_pin_mode_t'(s_r.cfg[IN_MODE_LSB +: 2]);
    drv_mode = output_drive_mode_t'(s_r.cfg[DRV_MODE_LSB +: 2]);
    src_sel = output_source_select_t'(s_r.cfg[SRC_SEL_LSB +: 2]);
    fall = s_r.din_prev && !s_r.din_s2;
    blink_gate = !blink_enable_flag_i ||
      (s_r.blink_cnt < BLINK_CNT_W'(BLINK_HIGH_COUNT));
    case (src_sel)
      SRC_COMPARATOR: src_level = comparator_i;
      SRC_CMD_BUSY: src_level = cmd_busy_i;
      SRC_FIELD: src_level = field_i;
      default: src_level = (|status_i) && blink_gate;
    endcase

    s_nxt = s_r;
    s_nxt.start_pulse = 1'b0;
    s_nxt.log_pulse = 1'b0;
    if (cfg_wr_i.we && cfg_wr_i.addr == CFG_BYTE_ADDR) begin
      s_nxt.cfg = cfg_wr_i.wdata;
    end
    if (cfg_rd_addr_i == CFG_BYTE_ADDR) begin
      s_nxt.rdata = s_r.cfg;
    end else begin
      s_nxt.rdata = 8'h00;
    end
    s_nxt.din_s1 = din_i;
    s_nxt.din_s2 = s_r.din_s1;
    s_nxt.din_prev = s_r.din_s2;
    if (slow_oscillator_tick_i) begin
      if (s_r.blink_cnt == BLINK_CNT_W'(BLINK_PERIOD - 1)) begin
        s_nxt.blink_cnt = '0;
      end else begin
        s_nxt.blink_cnt = s_r.blink_cnt + 1'b1;
      end
    end
    case (s_r.state)
      ST_IDLE: begin
        if (arm_i) begin
          s_nxt.state = ST_WAITING;
        end
      end
      ST_WAITING: begin
        if (stop_i) begin
          s_nxt.state = ST_IDLE;
        end else if ((gpio_mode && in_mode == IN_START_EDGE && fall) ||
                     (timed_start_flag_i && start_delay_done_i)) begin
          s_nxt.state = ST_ACTIVE;
          s_nxt.start_pulse = 1'b1;
        end
      end
      ST_ACTIVE: begin
        if (stop_i) begin
          s_nxt.state = ST_IDLE;
        end else if (gpio_mode && in_mode == IN_LOG_EDGE && fall) begin
          s_nxt.log_pulse = 1'b1;
        end
      end
      default: s_nxt.state = ST_IDLE;
    endcase
    // State levels kept in flops so the outputs need no decoding
    s_nxt.waiting = (s_nxt.state == ST_WAITING);
    s_nxt.active = (s_nxt.state == ST_ACTIVE);
    s_nxt.in_pull_up = 1'b0;
    s_nxt.in_pull_down = 1'b0;
    if (gpio_mode) begin
      case (in_mode)
        IN_PULL_DOWN: s_nxt.in_pull_down = 1'b1;
        IN_PULL_LOG: s_nxt.in_pull_up = log_busy_i;
        IN_START_EDGE: s_nxt.in_pull_up = (s_r.state == ST_WAITING);
        default: s_nxt.in_pull_up = (s_r.state == ST_ACTIVE);
      endcase
    end
    s_nxt.dout_pull_up = 1'b0;
    s_nxt.dout_pull_down = 1'b0;
    if (chip_enable_i) begin
      s_nxt.dout_o = serial_dout_i;
      s_nxt.dout_oe = 1'b1;
    end else if (gpio_mode && app_mode_i) begin
      case (drv_mode)
        DRV_PUSH_PULL: begin
          s_nxt.dout_o = src_level;
          s_nxt.dout_oe = 1'b1;
        end
        DRV_PULL_UP: begin
          s_nxt.dout_o = src_level;
          s_nxt.dout_oe = 1'b0;
          s_nxt.dout_pull_up = 1'b1;
        end
        DRV_PULL_DOWN: begin
          s_nxt.dout_o = !src_level;
          s_nxt.dout_oe = 1'b0;
          s_nxt.dout_pull_down = 1'b1;
        end
        default: begin
          s_nxt.dout_o = 1'b0;
          s_nxt.dout_oe = 1'b0;
        end
      endcase
    end else begin
      s_nxt.dout_o = 1'b0;
      s_nxt.dout_oe = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
      s_r.cfg <= CFG_RESET;
      s_r.din_s1 <= 1'b1;
      s_r.din_s2 <= 1'b1;
      s_r.din_prev <= 1'b1;
      s_r.state <= ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cfg_rdata_o = s_r.rdata;
  assign din_pull_up_o = s_r.in_pull_up;
  assign din_pull_down_o = s_r.in_pull_down;
  assign start_pulse_o = s_r.start_pulse;
  assign log_event_o = s_r.log_pulse;
  assign waiting_o = s_r.waiting;
  assign active_o = s_r.active;
  assign dout_o = s_r.dout_o;
  assign dout_oe_o = s_r.dout_oe;
  assign dout_pull_up_o = s_r.dout_pull_up;
  assign dout_pull_down_o = s_r.dout_pull_down;

  // Assertions
  sequence fall_seen;
    s_r.din_prev && !s_r.din_s2;
  endsequence

  serial_owns_dout_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    chip_enable_i |=> dout_oe_o && dout_o == $past(serial_dout_i))
    else $error("dout not serial while chip enable high");
  pull_down_mode_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (gpio_mode && in_mode == IN_PULL_DOWN) |=> din_pull_down_o && !din_pull_up_o)
    else $error("input pull-down missing");
  log_pull_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (gpio_mode && in_mode == IN_PULL_LOG) |=> din_pull_up_o == $past(log_busy_i))
    else $error("pull-up not tied to logging event");
  edge_start_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (s_r.state == ST_WAITING && !stop_i && gpio_mode && in_mode == IN_START_EDGE)
      ##0 fall_seen |=> active_o && start_pulse_o)
    else $error("falling edge did not start");
  timed_start_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (waiting_o && !stop_i && timed_start_flag_i && start_delay_done_i) |=> active_o)
    else $error("start delay expiry ignored");
  edge_log_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (active_o && !stop_i && gpio_mode && in_mode == IN_LOG_EDGE) ##0 fall_seen
      |=> log_event_o ##1 !log_event_o)
    else $error("log event not one pulse per edge");
  invert_pd_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!chip_enable_i && gpio_mode && app_mode_i && drv_mode == DRV_PULL_DOWN)
      |=> dout_o == !$past(src_level) && dout_pull_down_o)
    else $error("pull-down output not inverted");
  highz_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!chip_enable_i && drv_mode == DRV_HIGH_Z) |=> !dout_oe_o && !dout_pull_up_o)
    else $error("high impedance mode drives");
  field_src_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!chip_enable_i && gpio_mode && app_mode_i && drv_mode == DRV_PUSH_PULL &&
      src_sel == SRC_FIELD) |=> dout_o == $past(field_i))
    else $error("field source mismatch");
  blink_low_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (src_sel == SRC_STATUS_OR && blink_enable_flag_i &&
      s_r.blink_cnt >= BLINK_CNT_W'(BLINK_HIGH_COUNT)) |-> !src_level)
    else $error("blink gate open in low phase");

  // Blink pattern
  blink_high_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (src_sel == SRC_STATUS_OR && s_r.blink_cnt < BLINK_CNT_W'(BLINK_HIGH_COUNT)) |->
      src_level == (|status_i)) else $error("blink gate shut in high phase");
  blink_wrap_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (slow_oscillator_tick_i && s_r.blink_cnt == BLINK_CNT_W'(BLINK_PERIOD - 1)) |=>
      s_r.blink_cnt == '0) else $error("blink counter did not wrap");

  // Configuration byte
  cfg_store_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (cfg_wr_i.we && cfg_wr_i.addr == CFG_BYTE_ADDR) |=> s_r.cfg == $past(cfg_wr_i.wdata))
    else $error("configuration write lost");
  cfg_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (cfg_rd_addr_i == CFG_BYTE_ADDR) |=> cfg_rdata_o == $past(s_r.cfg))
    else $error("configuration read wrong");
  other_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (cfg_rd_addr_i != CFG_BYTE_ADDR) |=> cfg_rdata_o == 8'h00)
    else $error("other address did not read zero");

  // Input pin pulls
  start_pull_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (gpio_mode && in_mode == IN_START_EDGE) |=> din_pull_up_o == $past(s_r.state == ST_WAITING))
    else $error("pull-up not tied to waiting");
  active_pull_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (gpio_mode && in_mode == IN_LOG_EDGE) |=> din_pull_up_o == $past(s_r.state == ST_ACTIVE))
    else $error("pull-up not tied to active");
  no_gpio_pulls_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !gpio_mode |=> !din_pull_up_o && !din_pull_down_o)
    else $error("input pulls on outside general purpose mode");
  pd_input_off_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (gpio_mode && in_mode != IN_PULL_DOWN) |=> !din_pull_down_o)
    else $error("input pull-down on in wrong mode");

  // Output pin
  dout_released_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!chip_enable_i && !(gpio_mode && app_mode_i)) |=>
      !dout_oe_o && !dout_o && !dout_pull_up_o && !dout_pull_down_o)
    else $error("output driven outside application mode");
  push_pull_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!chip_enable_i && gpio_mode && app_mode_i && drv_mode == DRV_PUSH_PULL) |=>
      dout_oe_o && dout_o == $past(src_level))
    else $error("push-pull output wrong");
  pull_up_out_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!chip_enable_i && gpio_mode && app_mode_i && drv_mode == DRV_PULL_UP) |=>
      !dout_oe_o && dout_pull_up_o && dout_o == $past(src_level))
    else $error("pull-up output wrong");
  comp_src_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!chip_enable_i && gpio_mode && app_mode_i && drv_mode == DRV_PUSH_PULL &&
      src_sel == SRC_COMPARATOR) |=> dout_o == $past(comparator_i))
    else $error("comparator source mismatch");
  cmd_src_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!chip_enable_i && gpio_mode && app_mode_i && drv_mode == DRV_PUSH_PULL &&
      src_sel == SRC_CMD_BUSY) |=> dout_o == $past(cmd_busy_i))
    else $error("command source mismatch");
  status_or_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (src_sel == SRC_STATUS_OR && !blink_enable_flag_i) |-> src_level == (|status_i))
    else $error("status flags not ORed");
  serial_pulls_off_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    chip_enable_i |=> !dout_pull_up_o && !dout_pull_down_o)
    else $error("output pull on in serial mode");

  // Logging state
  arm_wait_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (s_r.state == ST_IDLE && arm_i) |=> waiting_o && !active_o)
    else $error("arm did not enter waiting");
  stop_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (stop_i && (waiting_o || active_o)) |=> !waiting_o && !active_o)
    else $error("stop did not return to idle");
  start_once_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    start_pulse_o |=> !start_pulse_o)
    else $error("start pulse longer than one cycle");
  start_active_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    start_pulse_o |-> active_o)
    else $error("start pulse without active state");
  log_mode_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    log_event_o |-> $past(gpio_mode && in_mode == IN_LOG_EDGE))
    else $error("log event in wrong input mode");
  no_edge_log_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !fall |=> !log_event_o)
    else $error("log event without falling edge");
  fall_once_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    fall |=> !fall)
    else $error("one edge seen twice");
endmodule

/* File: test/pin_env_model.sv */
// Outside circuit on the input pin: an external driver plus the pin's own pulls
`timescale 1ns/1ps
module pin_env_model (
  // Clock for tracking the last driven level
  input wire logic ref_clk_i,
  // External driver and pulls
  input wire logic drive_en_i,
  input wire logic drive_lvl_i,
  input wire logic pull_up_i,
  input wire logic pull_down_i,
  // Pin level seen by the block
  output logic din_o
);
  logic last_lvl_r = 1'b1;
  // A released pin with no pull shows the inverse of the last driven level
  always @(posedge ref_clk_i) begin
    if (drive_en_i) last_lvl_r <= drive_lvl_i;
  end
  assign din_o = drive_en_i ? drive_lvl_i : pull_up_i ? 1'b1 : pull_down_i ? 1'b0 : ~last_lvl_r;
endmodule

/* File: test/test_tag_gpio_pin_function.sv */
// Self-checking bench for the IO pin function block
`timescale 1ns/1ps
module test_tag_gpio_pin_function;
  import gpio_pin_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  cfg_write_t wr = '0;
  logic [10:0] rd_addr = 11'h000;
  logic ce = 1'b0, lock = 1'b0, app = 1'b1, sdout = 1'b0, tstart = 1'b0, delay_done = 1'b0;
  logic busy = 1'b0, arm = 1'b0, stop = 1'b0, comp = 1'b0, cmd = 1'b0, fld = 1'b0;
  logic blink = 1'b0, tick = 1'b0, ext_en = 1'b1, ext_lvl = 1'b1, lv;
  status_flags_t stat = '0;
  logic din, pu, pd, sp, ev, wt, ac, dq, oe, dpu, dpd;
  logic [7:0] rdata;
  int mismatches = 0, checked = 0, starts = 0, events = 0, hi;

  initial forever #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    if (sp === 1'b1) starts++;
    if (ev === 1'b1) events++;
  end

  tag_gpio_pin_function dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cfg_wr_i(wr),
    .cfg_rd_addr_i(rd_addr), .cfg_rdata_o(rdata), .chip_enable_i(ce), .serial_lock_i(lock),
    .app_mode_i(app), .serial_dout_i(sdout), .timed_start_flag_i(tstart),
    .start_delay_done_i(delay_done), .log_busy_i(busy), .arm_i(arm), .stop_i(stop),
    .comparator_i(comp), .cmd_busy_i(cmd), .field_i(fld), .status_i(stat),
    .blink_enable_flag_i(blink), .slow_oscillator_tick_i(tick), .din_i(din),
    .din_pull_up_o(pu), .din_pull_down_o(pd), .start_pulse_o(sp), .log_event_o(ev),
    .waiting_o(wt), .active_o(ac), .dout_o(dq), .dout_oe_o(oe), .dout_pull_up_o(dpu),
    .dout_pull_down_o(dpd));
  pin_env_model env (.ref_clk_i(ref_clk_i), .drive_en_i(ext_en), .drive_lvl_i(ext_lvl),
    .pull_up_i(pu), .pull_down_i(pd), .din_o(din));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic wr_cfg(input logic [7:0] d);
    wr = '{we: 1'b1, addr: CFG_BYTE_ADDR, wdata: d};
    cyc(1);
    wr.we = 1'b0;
    cyc(2);
  endtask
  task automatic rd_cfg(input logic [10:0] a, input logic [7:0] exp);
    rd_addr = a;
    cyc(1);
    chk(rdata, exp);
  endtask
  task automatic press;
    ext_en = 1'b1;
    ext_lvl = 1'b0;
    cyc(4);
    ext_en = 1'b0;
    cyc(4);
  endtask
  task automatic pulse_arm(input bit use_delay);
    arm = 1'b1;
    cyc(1);
    arm = 1'b0;
    delay_done = use_delay;
    cyc(2);
    delay_done = 1'b0;
    cyc(1);
  endtask
  task automatic complete_run;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    cyc(3);
    rst_n_i = 1'b1;
    cyc(2);
    rd_cfg(CFG_BYTE_ADDR, CFG_RESET);
    rd_cfg(11'h438, 8'h00);
    chk(8'({oe, dpu, dpd, pd, pu}), 8'h02);
    for (int m = 0; m < 3; m++) begin
      for (int s = 0; s < 3; s++) begin
        wr_cfg(8'((s << 6) | (m << 4)));
        for (int v = 0; v < 2; v++) begin
          lv = v[0];
          comp = (s == 0) ? lv : ~lv;
          cmd = (s == 1) ? lv : ~lv;
          fld = (s == 2) ? lv : ~lv;
          cyc(1);
          chk(8'({dq, oe, dpu, dpd}), 8'({(m == 2) ^ lv, m == 0, m == 1, m == 2}));
        end
      end
    end
    wr_cfg(8'hC0);
    for (int i = 0; i < 5; i++) begin
      stat = status_flags_t'(4'(1 << i));
      cyc(1);
      chk(8'(dq), 8'(i < 4));
    end
    stat = 4'hF;
    blink = 1'b1;
    tick = 1'b1;
    hi = 0;
    for (int k = 0; k < BLINK_PERIOD_TICKS; k++) begin
      cyc(1);
      hi += int'(dq === 1'b1);
    end
    chk(8'(hi), 8'(BLINK_HIGH_TICKS));
    tick = 1'b0;
    wr_cfg(8'h30);
    ce = 1'b1;
    for (int v = 0; v < 2; v++) begin
      sdout = v[0];
      cyc(1);
      chk(8'({dq, oe}), 8'({v[0], 1'b1}));
    end
    ce = 1'b0;
    wr_cfg(8'h00);
    app = 1'b0;
    cyc(1);
    chk(8'(oe), 8'h00);
    app = 1'b1;
    lock = 1'b1;
    cyc(1);
    chk(8'(oe), 8'h00);
    lock = 1'b0;
    cyc(1);
    chk(8'({oe, pd, pu}), 8'h06);
    wr_cfg(8'h01);
    chk(8'({pd, pu}), 8'h00);
    busy = 1'b1;
    cyc(2);
    chk(8'(pu), 8'h01);
    busy = 1'b0;
    wr_cfg(8'h02);
    pulse_arm(1'b0);
    chk(8'({wt, ac, pu}), 8'h05);
    press();
    chk(8'({7'(starts), ac}), 8'h03);
    ext_en = 1'b1;
    ext_lvl = 1'b1;
    stop = 1'b1;
    cyc(1);
    stop = 1'b0;
    tstart = 1'b1;
    pulse_arm(1'b1);
    chk(8'({ac, 7'(starts)}), 8'h82);
    press();
    chk(8'(starts), 8'h02);
    ext_en = 1'b1;
    ext_lvl = 1'b1;
    stop = 1'b1;
    cyc(1);
    stop = 1'b0;
    wr_cfg(8'h03);
    pulse_arm(1'b1);
    chk(8'({ac, pu}), 8'h03);
    press();
    press();
    chk(8'(events), 8'h02);
    complete_run();
  end
endmodule
